// ### dwl_regs.svh
/*
 * register map, field positions, reset values and timing counts of the
 * write leveling and calibration readout block.
 * assumes a 100 MHz hclk and a slower link clock sampled by it.
 */
`ifndef DWL_REGS_SVH
`define DWL_REGS_SVH

// ============================================================
// register offsets (byte addresses)
`define DWL_OFS_CTRL 12'h000
`define DWL_OFS_STATUS 12'h004
`define DWL_OFS_MR1 12'h008
`define DWL_OFS_MR3 12'h00C

// ============================================================
// control register fields
`define DWL_CTRL_PRIME_ONLY 0
`define DWL_CTRL_MPR_COPY 1
`define DWL_CTRL_OTF_EN 2
`define DWL_CTRL_FIXED_BC4 3
`define DWL_CTRL_DLL_LOCKED 4
`define DWL_CTRL_RL_LSB 8
`define DWL_CTRL_RL_W 4
`define DWL_CTRL_RESET 32'h0000_0605

// ============================================================
// status register fields
`define DWL_ST_WL 0
`define DWL_ST_MPR 1
`define DWL_ST_DQS_TERM 2
`define DWL_ST_DQ_TERM 3
`define DWL_ST_SAMPLE 4
`define DWL_ST_ODT_OK 5
`define DWL_ST_BURST 6
`define DWL_ST_QUIET 7

// ============================================================
// mode register bit positions
`define DWL_MR1_WL 7
`define DWL_MR1_QOFF 12
`define DWL_MR3_MPR 2
`define DWL_MR1_RESET 16'h0000
`define DWL_MR3_RESET 3'h0
`define DWL_BA_MR1 3'h1
`define DWL_BA_MR3 3'h3
`define DWL_ADDR_BC_N 12
`define DWL_ADDR_NIB 2

// ============================================================
// timing: clock rate, mode register delay, leveling output delay
`define DWL_HCLK_MHZ 100
`define DWL_TMOD_NCK 12
`define DWL_TWLO_NS 9
`define DWL_TWLO_RAW ((`DWL_TWLO_NS * `DWL_HCLK_MHZ) / 1000)
`define DWL_TWLO_CYC ((`DWL_TWLO_RAW < 1) ? 1 : `DWL_TWLO_RAW)
`define DWL_BEATS_BL8 4'h8
`define DWL_BEATS_BC4 4'h4

`endif

// ### dwl_pkg.sv
/*
 * types shared by the write leveling and calibration readout block.
 * assumes dwl_regs.svh for all numeric constants.
 */
package dwl_pkg;

	// ============================================================
	// calibration readout sequencer states
	typedef enum logic [1:0] {
		DWL_RD_IDLE = 2'b00,
		DWL_RD_WAIT = 2'b01,
		DWL_RD_BURST = 2'b10
	} dwl_rd_state_e;

	// ============================================================
	// decoded link command
	typedef enum logic [1:0] {
		DWL_CMD_NOP = 2'b00,
		DWL_CMD_MRS = 2'b01,
		DWL_CMD_READ = 2'b10,
		DWL_CMD_OTHER = 2'b11
	} dwl_cmd_e;

endpackage : dwl_pkg

// ### dwl_sync.sv
/*
 * two flip-flop synchroniser for a bundle of pins.
 * assumes the caller reads only q, never an inner stage.
 */
`timescale 1ns/1ps

module dwl_sync #(
	parameter int W = 1
) (
	// clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic ce,
	// pins in, synchronised out
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);

	logic [W-1:0] meta_q;

	// two stages, first one feeds only the second
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			meta_q <= '0;
			q <= '0;
		end else if (ce) begin
			meta_q <= d;
			q <= meta_q;
		end
	end

endmodule : dwl_sync

// ### dwl_ahb_regs.sv
/*
 * ahb-lite slave holding the control register and showing status.
 * assumes single word transfers; answers with no wait state, always okay.
 */
`timescale 1ns/1ps
`include "dwl_regs.svh"

module dwl_ahb_regs (
	// clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic ce,
	// ahb-lite slave
	input wire logic hsel,
	input wire logic [11:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic hready,
	input wire logic [31:0] hwdata,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	// block side
	output logic [31:0] ctrl_q,
	input wire logic [31:0] status,
	input wire logic [31:0] mr1_view,
	input wire logic [31:0] mr3_view
);

	logic wr_pend_q;
	logic [11:0] wr_addr_q;
	logic take;

	assign take = hsel && hready && htrans[1];

	// address phase capture for writes
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_q <= 1'b0;
			wr_addr_q <= 12'h000;
		end else if (ce) begin
			wr_pend_q <= take && hwrite && (hsize == 3'h2);
			wr_addr_q <= haddr;
		end
	end

	// control register written in the data phase
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ctrl_q <= `DWL_CTRL_RESET;
		end else if (ce && wr_pend_q && wr_addr_q == `DWL_OFS_CTRL) begin
			ctrl_q <= hwdata;
		end
	end

	// read data registered at the address phase, unmapped reads zero
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata <= 32'h0000_0000;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end else if (ce) begin
			hreadyout <= 1'b1;
			hresp <= 1'b0;
			if (take && !hwrite) begin
				case (haddr)
					`DWL_OFS_CTRL: hrdata <= ctrl_q;
					`DWL_OFS_STATUS: hrdata <= status;
					`DWL_OFS_MR1: hrdata <= mr1_view;
					`DWL_OFS_MR3: hrdata <= mr3_view;
					default: hrdata <= 32'h0000_0000;
				endcase
			end
		end
	end

endmodule : dwl_ahb_regs

// ### dwl_core.sv
/*
 * ddr3 device side write leveling and calibration readout logic.
 * assumes the controller drives ck, commands, odt and dqs as pins; they are
 * sampled by hclk, which must run well above the link clock.
 */
// What this block does
// - mr1 a7 enters, clearing exits leveling
// - leveling odt switches dqs termination only
// - exit mrs may change other mr1 bits
// - odt accepted only tmod after entry
// - dqs rise samples ck, shown after twlo
// - feedback on prime bit, others low if prime only is set, else copies
// - dq undefined until tmod after exit
// - mr3 a2 enables calibration readout
// - reads redirected, location from mr3 a1:a0
// - read with auto-precharge acts as read
// - dq0 carries bit, others copy or zero
// - column a2 picks nibble burst order in bc4 only
// - bank and upper address ignored, bc selectable
// - normal latency, only after dll lock
// - burst bit 0 lsb, bit 7 msb
// - location zero returns alternating 0,1 pattern
`timescale 1ns/1ps
`include "dwl_regs.svh"

module dwl_core
	import dwl_pkg::*;
(
	// clock, reset, enable
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic ce,
	// ahb-lite register bus
	input wire logic hsel,
	input wire logic [11:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic hready,
	input wire logic [31:0] hwdata,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	// ddr3 command side pins
	input wire logic ck,
	input wire logic cs_n,
	input wire logic ras_n,
	input wire logic cas_n,
	input wire logic we_n,
	input wire logic [2:0] ba,
	input wire logic [14:0] addr,
	input wire logic odt,
	input wire logic dqs,
	// ddr3 data pins and termination
	output logic [7:0] dq_o,
	output logic [7:0] dq_oe,
	output logic dqs_term_en,
	output logic dq_term_en
);

	// ============================================================
	// pin synchronisation
	localparam int PW = 25;
	logic [PW-1:0] pins_s;
	logic ck_s, dqs_s, odt_s, cs_n_s, ras_n_s, cas_n_s, we_n_s;
	logic [2:0] ba_s;
	logic [14:0] addr_s;

	dwl_sync #(
		.W(PW)
	) u_sync (
		.hclk(hclk),
		.hresetn(hresetn),
		.ce(ce),
		.d({ck, dqs, odt, cs_n, ras_n, cas_n, we_n, ba, addr}),
		.q(pins_s)
	);

	assign {ck_s, dqs_s, odt_s, cs_n_s, ras_n_s, cas_n_s, we_n_s, ba_s, addr_s} = pins_s;

	// ============================================================
	// register bus
	logic [31:0] ctrl_q;
	logic [31:0] status;
	logic [31:0] mr1_view;
	logic [31:0] mr3_view;

	dwl_ahb_regs u_regs (
		.hclk(hclk),
		.hresetn(hresetn),
		.ce(ce),
		.hsel(hsel),
		.haddr(haddr),
		.htrans(htrans),
		.hwrite(hwrite),
		.hsize(hsize),
		.hready(hready),
		.hwdata(hwdata),
		.hrdata(hrdata),
		.hreadyout(hreadyout),
		.hresp(hresp),
		.ctrl_q(ctrl_q),
		.status(status),
		.mr1_view(mr1_view),
		.mr3_view(mr3_view)
	);

	// ============================================================
	// command decode
	function automatic dwl_cmd_e dwl_decode(input logic cs, input logic ras, input logic cas, input logic we);
		if (cs) begin
			return DWL_CMD_NOP;
		end
		case ({ras, cas, we})
			3'b000: return DWL_CMD_MRS;
			3'b101: return DWL_CMD_READ;
			3'b111: return DWL_CMD_NOP;
			default: return DWL_CMD_OTHER;
		endcase
	endfunction : dwl_decode

	// link clock and strobe edges
	logic ck_d_q, dqs_d_q;
	logic ck_rise, ck_edge, dqs_rise;
	dwl_cmd_e cmd;
	logic mrs_mr1, mrs_mr3, rd_cmd;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ck_d_q <= 1'b0;
			dqs_d_q <= 1'b0;
		end else if (ce) begin
			ck_d_q <= ck_s;
			dqs_d_q <= dqs_s;
		end
	end

	assign ck_rise = ck_s && !ck_d_q;
	assign ck_edge = ck_s != ck_d_q;
	assign dqs_rise = dqs_s && !dqs_d_q;
	assign cmd = dwl_decode(cs_n_s, ras_n_s, cas_n_s, we_n_s);
	assign mrs_mr1 = ck_rise && cmd == DWL_CMD_MRS && ba_s == `DWL_BA_MR1;
	assign mrs_mr3 = ck_rise && cmd == DWL_CMD_MRS && ba_s == `DWL_BA_MR3;
	assign rd_cmd = ck_rise && cmd == DWL_CMD_READ;

	// ============================================================
	// mode register shadows
	logic [15:0] mr1_q;
	logic [2:0] mr3_q;
	logic wl_on, qoff, mpr_on;

	// whole mr1 image taken on every mr1 write, exit included
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			mr1_q <= `DWL_MR1_RESET;
			mr3_q <= `DWL_MR3_RESET;
		end else if (ce) begin
			if (mrs_mr1) begin
				mr1_q <= {1'b0, addr_s};
			end
			if (mrs_mr3) begin
				mr3_q <= addr_s[2:0];
			end
		end
	end

	assign wl_on = mr1_q[`DWL_MR1_WL];
	assign qoff = mr1_q[`DWL_MR1_QOFF];
	assign mpr_on = mr3_q[`DWL_MR3_MPR];

	// ============================================================
	// tmod guard after every mr1 write, counted in link clocks
	logic [3:0] tmod_q;
	logic odt_ok;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			tmod_q <= 4'h0;
		end else if (ce) begin
			if (mrs_mr1) begin
				tmod_q <= 4'(`DWL_TMOD_NCK);
			end else if (ck_rise && tmod_q != 4'h0) begin
				tmod_q <= tmod_q - 4'h1;
			end
		end
	end

	assign odt_ok = tmod_q == 4'h0;

	// ============================================================
	// termination: in leveling odt switches dqs only
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			dqs_term_en <= 1'b0;
			dq_term_en <= 1'b0;
		end else if (ce) begin
			if (wl_on) begin
				dqs_term_en <= odt_s && odt_ok;
				dq_term_en <= 1'b0;
			end else begin
				dqs_term_en <= odt_s;
				dq_term_en <= odt_s;
			end
		end
	end

	// ============================================================
	// leveling sample of ck on strobe rise, shown after twlo
	logic sample_q, wl_fb_q, wl_first_q;
	logic [7:0] twlo_q;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			sample_q <= 1'b0;
			twlo_q <= 8'h00;
			wl_fb_q <= 1'b0;
			wl_first_q <= 1'b0;
		end else if (ce) begin
			if (!wl_on) begin
				twlo_q <= 8'h00;
				wl_first_q <= 1'b0;
			end else if (dqs_rise) begin
				sample_q <= ck_s;
				twlo_q <= 8'(`DWL_TWLO_CYC);
			end else if (twlo_q != 8'h00) begin
				twlo_q <= twlo_q - 8'h01;
				if (twlo_q == 8'h01) begin
					wl_fb_q <= sample_q;
					wl_first_q <= 1'b1;
				end
			end
		end
	end

	// ============================================================
	// calibration readout sequencer
	dwl_rd_state_e rd_state_q;
	logic [3:0] lat_q;
	logic [3:0] beat_q;
	logic [3:0] beats_q;
	logic nib_q;
	logic bc4;
	logic [2:0] order;
	logic mpr_bit;
	logic [`DWL_CTRL_RL_W-1:0] rl;

	assign rl = ctrl_q[`DWL_CTRL_RL_LSB +: `DWL_CTRL_RL_W];
	// a12 low chops when on-the-fly is on, else the fixed setting
	assign bc4 = ctrl_q[`DWL_CTRL_OTF_EN] ? !addr_s[`DWL_ADDR_BC_N] : ctrl_q[`DWL_CTRL_FIXED_BC4];

	// reads (with or without auto-precharge) go to the register
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rd_state_q <= DWL_RD_IDLE;
			lat_q <= 4'h0;
			beat_q <= 4'h0;
			beats_q <= 4'h0;
			nib_q <= 1'b0;
		end else if (ce) begin
			case (rd_state_q)
				DWL_RD_IDLE: begin
					if (mpr_on && rd_cmd && ctrl_q[`DWL_CTRL_DLL_LOCKED]) begin
						lat_q <= rl;
						beats_q <= bc4 ? `DWL_BEATS_BC4 : `DWL_BEATS_BL8;
						nib_q <= bc4 && addr_s[`DWL_ADDR_NIB];
						beat_q <= 4'h0;
						rd_state_q <= DWL_RD_WAIT;
					end
				end
				DWL_RD_WAIT: begin
					if (ck_rise) begin
						if (lat_q <= 4'h1) begin
							rd_state_q <= DWL_RD_BURST;
						end else begin
							lat_q <= lat_q - 4'h1;
						end
					end
				end
				DWL_RD_BURST: begin
					if (ck_edge) begin
						if (beat_q + 4'h1 == beats_q) begin
							rd_state_q <= DWL_RD_IDLE;
						end
						beat_q <= beat_q + 4'h1;
					end
				end
				default: rd_state_q <= DWL_RD_IDLE;
			endcase
		end
	end

	// burst order bit n is bit n of location zero's pattern
	assign order = {nib_q, beat_q[1:0]} | {beat_q[2], 2'b00};
	assign mpr_bit = (mr3_q[1:0] == 2'b00) ? order[0] : 1'b0;

	// ============================================================
	// dq drive: leveling feedback or readout beats
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			dq_o <= 8'h00;
			dq_oe <= 8'h00;
		end else if (ce) begin
			if (rd_state_q == DWL_RD_BURST) begin
				dq_o <= {(ctrl_q[`DWL_CTRL_MPR_COPY] ? {7{mpr_bit}} : 7'h00), mpr_bit};
				dq_oe <= 8'hFF;
			end else if (wl_on && !qoff && odt_ok && wl_first_q) begin
				dq_o <= {(ctrl_q[`DWL_CTRL_PRIME_ONLY] ? 7'h00 : {7{wl_fb_q}}), wl_fb_q};
				dq_oe <= 8'hFF;
			end else begin
				dq_o <= 8'h00;  // left undriven at entry and until tmod after exit
				dq_oe <= 8'h00;
			end
		end
	end

	// ============================================================
	// status views
	assign status = {24'h0, !odt_ok, rd_state_q == DWL_RD_BURST, odt_ok, wl_fb_q, dq_term_en, dqs_term_en, mpr_on,
		wl_on};
	assign mr1_view = {16'h0000, mr1_q};
	assign mr3_view = {29'h0, mr3_q};

endmodule : dwl_core

// ### dwl_core_monitor.sv
/*
 * port checker of the leveling and calibration readout core.
 * assumes one hclk domain and async active low hresetn.
 */
`timescale 1ns/1ps

module dwl_core_monitor (
	// clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// watched ports
	input wire logic odt,
	input wire logic hreadyout,
	input wire logic hresp,
	input wire logic [7:0] dq_o,
	input wire logic [7:0] dq_oe,
	input wire logic dqs_term_en,
	input wire logic dq_term_en
);
	// ============================================================
	// assertions
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	a_bus_ready: assert property (hreadyout)
		else $error("hreadyout low");
	a_bus_okay: assert property (!hresp)
		else $error("error response seen");
	a_dq_term_dqs: assert property (dq_term_en |-> dqs_term_en)
		else $error("dq termination without dqs termination");
	a_term_odt_off: assert property ((!odt) [*6] |-> !dqs_term_en && !dq_term_en)
		else $error("termination on with odt low");
	a_dq_copy_zero: assert property (|dq_oe |-> dq_o[7:1] == 7'h00 || dq_o[7:1] == {7{dq_o[0]}})
		else $error("upper dq neither copy nor zero");
	a_oe_all_none: assert property (dq_oe == 8'h00 || dq_oe == 8'hFF)
		else $error("partial dq enables");
	a_burst_min_len: assert property ($fell(dq_oe[0]) |-> $past(dq_oe[0], 12))
		else $error("dq drive shorter than a chopped burst");
	a_reset_quiet: assert property (disable iff (1'b0) !hresetn |-> dq_oe == 8'h00 && !dqs_term_en)
		else $error("outputs active in reset");
endmodule : dwl_core_monitor

bind dwl_core dwl_core_monitor dwl_core_monitor_inst (.hclk(hclk), .hresetn(hresetn), .odt(odt),
	.hreadyout(hreadyout), .hresp(hresp), .dq_o(dq_o), .dq_oe(dq_oe), .dqs_term_en(dqs_term_en),
	.dq_term_en(dq_term_en));

// ### dwl_ctrl_model.sv
/*
 * behavioural ddr3 controller driving ck, commands, odt and dqs.
 * assumes the bench calls its tasks one at a time.
 */
`timescale 1ns/1ps

module dwl_ctrl_model (
	// link clock
	output logic ck,
	// command pins
	output logic cs_n,
	output logic ras_n,
	output logic cas_n,
	output logic we_n,
	output logic [2:0] ba,
	output logic [14:0] addr,
	// odt and strobe
	output logic odt,
	output logic dqs
);
	// ============================================================
	// free running 80 ns link clock, idle pins
	initial begin
		{ck, odt, dqs, ba, addr} = 0;
		{cs_n, ras_n, cas_n, we_n} = 4'hF;
		#3;
		forever #40 ck = ~ck;
	end
	// one command at a ck rise, then deselect with scrambled lines
	task automatic cmd(input logic [3:0] c, input logic [2:0] b, input logic [14:0] a);
		@(negedge ck);
		{cs_n, ras_n, cas_n, we_n} = c;
		{ba, addr} = {b, a};
		@(negedge ck);
		{cs_n, ras_n, cas_n, we_n} = 4'hF; // only deselect between commands
		{ba, addr} = ~{b, a};
	endtask : cmd
	task automatic mrs(input logic [2:0] b, input logic [14:0] a);
		cmd(4'h0, b, a);
	endtask : mrs
	task automatic rd(input logic [2:0] b, input logic [14:0] a);
		cmd(4'h5, b, {a[14:2], 2'h0}); // column bits 1:0 held at zero
	endtask : rd
	task automatic wt(input int n);
		repeat (n) @(posedge ck); // tmod, tmrd, tmprr waits
	endtask : wt
	// odt change, then twldqsen before any strobe
	task automatic set_odt(input logic v);
		@(negedge ck);
		odt = v;
		wt(2);
	endtask : set_odt
	// single rising strobe d ns after a ck rise
	task automatic strobe(input int d);
		@(posedge ck);
		#d dqs = 1'b1;
		#30 dqs = 1'b0;
	endtask : strobe
endmodule : dwl_ctrl_model

// ### tb_top.sv
/*
 * self-checking bench of the leveling and calibration readout core.
 * assumes dwl_core, dwl_ctrl_model and the bound port checker.
 */
`timescale 1ns/1ps
`include "dwl_regs.svh"

module tb_top;
	logic hclk = 1'b0, hresetn = 1'b1, hsel = 1'b0, hwrite = 1'b0;
	logic [1:0] htrans = 2'h0;
	logic [11:0] haddr = 12'h000;
	logic [2:0] hsize = 3'h2;
	logic [31:0] hwdata = 32'h0, rv, rnd = 32'h9956F55D;
	wire logic hreadyout, hresp, ck, cs_n, ras_n, cas_n, we_n, odt, dqs, dqs_term_en, dq_term_en;
	wire logic [31:0] hrdata;
	wire logic [2:0] ba;
	wire logic [14:0] addr;
	wire logic [7:0] dq_o, dq_oe;
	int fail_count = 0, n_compared = 0, i, j, k, n, rl;
	logic cp, bc4, nib, b;
	logic [1:0] loc;
	logic [14:0] a;
	// ============================================================
	// clock, design and controller
	always #5 hclk = ~hclk;
	dwl_core dwl_core_inst (.hclk(hclk), .hresetn(hresetn), .ce(1'b1), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .ck(ck), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n),
		.ba(ba), .addr(addr), .odt(odt), .dqs(dqs), .dq_o(dq_o), .dq_oe(dq_oe), .dqs_term_en(dqs_term_en),
		.dq_term_en(dq_term_en));
	dwl_ctrl_model ctl (.ck(ck), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .ba(ba),
		.addr(addr), .odt(odt), .dqs(dqs));
	// ============================================================
	// helpers
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			fail_count++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk
	task automatic results;
		$display("compared %0d mismatches %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask : results
	// single ahb-lite word transfer, waits on hready
	task automatic ahb(input logic w, input logic [11:0] ad, input logic [31:0] wd, output logic [31:0] r);
		int t;
		t = 0;
		@(posedge hclk);
		{hsel, htrans, haddr, hwrite, hsize} <= {1'b1, 2'h2, ad, w, 3'h2};
		do begin @(posedge hclk); t++; end while (hreadyout !== 1'b1 && t < 40);
		{hsel, htrans, hwdata} <= {1'b0, 2'h0, wd};
		do begin @(posedge hclk); t++; end while (hreadyout !== 1'b1 && t < 80);
		r = hrdata;
		if (t >= 40) begin fail_count++; results(); end
	endtask : ahb
	// one leveling strobe and the feedback on dq
	task automatic lev(input logic [31:0] c, input int d, input logic [7:0] e, input logic [7:0] oe);
		ahb(1'b1, `DWL_OFS_CTRL, c, rv);
		ctl.strobe(d);
		repeat (10) @(posedge hclk);
		chk(dq_oe, oe);
		chk(dq_o & oe, e);
	endtask : lev
	initial begin #900000; fail_count++; results(); end
	// ============================================================
	// main sequence
	initial begin
		hresetn <= 1'b0; // falling edge at time zero so every flop resets before the first clock
		repeat (20) @(posedge hclk);
		hresetn <= 1'b1;
		ahb(1'b0, `DWL_OFS_CTRL, 32'h0, rv);
		chk(rv, `DWL_CTRL_RESET);
		ahb(1'b1, 12'h010, 32'hFFFFFFFF, rv);
		ahb(1'b0, 12'h010, 32'h0, rv);
		chk(rv, 32'h0);
		ctl.set_odt(1'b1);
		repeat (6) @(posedge hclk);
		chk({dqs_term_en, dq_term_en}, 2'h3);
		// leveling entry with outputs off, odt raised too early
		ctl.mrs(3'h1, 15'h1080);
		repeat (6) @(posedge hclk);
		chk({dqs_term_en, dq_term_en}, 2'h0);
		ctl.wt(`DWL_TMOD_NCK);
		repeat (6) @(posedge hclk);
		chk({dqs_term_en, dq_term_en}, 2'h2);
		lev(32'h605, 20, 8'h00, 8'h00);
		ctl.mrs(3'h1, 15'h0084); // outputs on, rtt nominal rzq/4
		ctl.wt(`DWL_TMOD_NCK);
		chk(dq_oe, 8'h00);
		for (k = 0; k < 4; k++) lev(32'h604 | k[1], k[0] ? 20 : 60, k[1] ? {7'h0, k[0]} : {8{k[0]}}, 8'hFF);
		ahb(1'b0, `DWL_OFS_STATUS, 32'h0, rv);
		chk(rv[`DWL_ST_WL], 1'b1);
		// leveling exit that also changes other mode bits
		ctl.set_odt(1'b0);
		ctl.mrs(3'h1, 15'h1A66);
		repeat (8) @(posedge hclk);
		chk(dq_oe, 8'h00);
		ctl.wt(`DWL_TMOD_NCK);
		ahb(1'b0, `DWL_OFS_MR1, 32'h0, rv);
		chk(rv, 32'h1A66);
		$display("test leveling done");
		// calibration readout bursts, random latency and don't-care bits
		for (i = 0; i < 5; i++) begin
			rnd = lfsr(rnd);
			rl = 5 + rnd[1:0];
			cp = rnd[2];
			bc4 = (i == 1 || i == 2);
			nib = (i == 2);
			loc = (i < 3) ? 2'h0 : i - 2;
			ahb(1'b1, `DWL_OFS_CTRL, (rl << 8) | 32'h10 | (cp << 1) | ((i == 1) ? 32'h8 : 32'h4), rv);
			ctl.mrs(3'h3, {12'h0, 1'b1, loc}); // all banks idle already
			ctl.wt(`DWL_TMOD_NCK);
			a = rnd[31:17];
			a[12] = (i == 1) | ~bc4; // pass 1 uses the fixed chop setting, a12 must be ignored
			a[2] = nib;
			ctl.rd(rnd[5:3], a); // bank, a10 and upper bits random
			n = 0;
			while (dq_oe[0] !== 1'b1 && n < 300) begin @(posedge hclk); n++; end
			if (n >= 300) begin fail_count++; results(); end
			chk(n >= rl * 8 - 4 && n <= rl * 8 + 4, 1'b1);
			repeat (2) @(posedge hclk);
			for (j = 0; j < (bc4 ? 4 : 8); j++) begin
				b = (loc == 2'h0) ? ((j + 4 * nib) & 1) : 1'b0;
				chk({dq_oe, dq_o}, {8'hFF, cp ? {8{b}} : {7'h0, b}});
				repeat (4) @(posedge hclk);
			end
			chk(dq_oe, 8'h00);
			ctl.wt(4);
			ctl.mrs(3'h3, 15'h0);
			ctl.wt(`DWL_TMOD_NCK);
			$display("test readout %0d done", i);
		end
		// refused reads: dll unlocked, then readout mode off
		for (k = 0; k < 2; k++) begin
			ahb(1'b1, `DWL_OFS_CTRL, k ? 32'h614 : 32'h604, rv);
			ctl.mrs(3'h3, k ? 15'h0 : 15'h4);
			ctl.wt(`DWL_TMOD_NCK);
			ctl.rd(3'h0, 15'h1000);
			n = 0;
			repeat (150) begin @(posedge hclk); n += dq_oe[0]; end
			chk(n, 0);
		end
		// reset in mid run clears the outputs
		hresetn <= 1'b0;
		repeat (3) @(posedge hclk);
		chk({dq_oe, dqs_term_en}, 9'h0);
		hresetn <= 1'b1;
		ahb(1'b0, `DWL_OFS_CTRL, 32'h0, rv);
		chk(rv, `DWL_CTRL_RESET);
		ahb(1'b0, `DWL_OFS_MR1, 32'h0, rv);
		chk(rv, 32'h0);
		$display("test reset done");
		results();
	end
endmodule : tb_top
